/* File: core/ptpc_timer.sv */
// Periodic timer single-pulse and capture modes with an Avalon-MM register slave.
// Assumes pins are asynchronous and the bus master holds requests until waitrequest is low.
// Contract
// - Pulse mode: mode 10, pin-action 11
// - Run bit set by write or pin
// - Run rising starts count, output leading edge
// - Run clear gives trailing edge
// - A match clears run bit
// - A match raises interrupt in pulse mode
// - Counter zeroed only at run rise in pulse mode
// - P and clear-select unused in pulse
// - Capture mode: mode field 01
// - Capture source: capture or clock pin
// - Pin-action picks rising, falling, both
// - Pin-action 11: no capture, count continues
// - Capture counter starts on software run
// - Edge copies counter to A, interrupt
// - Captures never stop or reset counter
// - P match resets counter in capture
// - P match raises interrupt in capture
// - P zero: run to maximum
// - Capture mode: no output function
// - Capture works with pin as output
// - Ten-bit counter overflows at maximum
// - A and P ten bits, low/high bytes
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
module ptpc_timer
  import ptpc_pkg::*;
#(
  parameter int CNT_W = ptpc_pkg::PTPC_CNT_W
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        ext_timer_clock_pin_i,
  input  wire logic        dedicated_capture_pin_i,
  output logic             timer_out_o,
  output logic             timer_irq_o
);
  import ptpc_pkg::*;

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  initial begin
    if (CNT_W != PTPC_CNT_W) $error("ptpc_timer supports only a 10-bit counter");
    if (PTPC_SYNC_LEN != 3) $error("ptpc_timer needs three-stage pin synchronisers");
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic clk_pin_s;
  logic cap_pin_s;
  logic clk_pin_q;
  logic cap_pin_q;

  ptpc_sync u_sync_clk (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (ext_timer_clock_pin_i),
    .level_o (clk_pin_s)
  );

  // Capture pin is read as an input even when shared as an output
  ptpc_sync u_sync_cap (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (dedicated_capture_pin_i),
    .level_o (cap_pin_s)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_pin_q <= 1'b0;
      cap_pin_q <= 1'b0;
    end else begin
      clk_pin_q <= clk_pin_s;
      cap_pin_q <= cap_pin_s;
    end
  end

  // ****************************************************************
  // Registers and decode
  // ****************************************************************
  ptpc_ctrl_t        ctrl_q;
  logic [CNT_W-1:0]  cmpa_q;
  logic [CNT_W-1:0]  cmpp_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              run_q;
  logic              run_prev_q;
  logic              out_q;
  logic              irq_q;
  logic              capture_seen_q;
  logic              ack_q;
  ptpc_avm_req_t     req;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic pick(input logic sel, input logic on_clk, input logic on_cap);
    pick = sel ? on_clk : on_cap;
  endfunction

  assign req.read       = avs_read_i;
  assign req.write      = avs_write_i;
  assign req.address    = avs_address_i;
  assign req.byteenable = avs_byteenable_i;
  assign req.writedata  = avs_writedata_i;

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // One wait cycle per access keeps read data registered
  assign avs_waitrequest_o = (req.read | req.write) & ~ack_q;

  // Writes commit where waitrequest is low, so a stalled master never writes early
  logic wr_go;
  logic rd_go;
  assign wr_go = req.write & ack_q;
  assign rd_go = req.read & ~ack_q;

  // ****************************************************************
  // Write strobes
  // ****************************************************************
  logic wr_ctrl;
  logic wr_cmpa;
  logic wr_cmpp;
  logic wr_stat;
  assign wr_ctrl = wr_go & hit(req.address, PTPC_OFS_CTRL);
  assign wr_cmpa = wr_go & hit(req.address, PTPC_OFS_CMPA);
  assign wr_cmpp = wr_go & hit(req.address, PTPC_OFS_CMPP);
  assign wr_stat = wr_go & hit(req.address, PTPC_OFS_STAT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (req.read | req.write) & ~ack_q;
    end
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  logic pulse_mode;
  logic cap_mode;
  assign pulse_mode = (ctrl_q.timer_mode_field == PTPC_MODE_PULSE) &
                      (ctrl_q.pin_action_field == PTPC_PIN_NONE);
  assign cap_mode   = (ctrl_q.timer_mode_field == PTPC_MODE_CAPTURE);

  logic             run_rise;
  logic             match_a;
  logic             match_p;
  logic [CNT_W-1:0] wrap_pt;
  assign run_rise = run_q & ~run_prev_q;
  assign match_a  = pulse_mode & run_q & ~run_rise & (cnt_q == cmpa_q);
  // Zero P lets the counter reach full scale before wrapping
  assign wrap_pt  = (cmpp_q == '0) ? PTPC_CNT_MAX : cmpp_q;
  assign match_p  = cap_mode & run_q & ~run_rise & (cnt_q == wrap_pt);

  // ****************************************************************
  // Capture edge select
  // ****************************************************************
  logic cap_now;
  logic cap_prev;
  logic cap_edge;
  assign cap_now  = pick(ctrl_q.capture_source_select, clk_pin_s, cap_pin_s);
  assign cap_prev = pick(ctrl_q.capture_source_select, clk_pin_q, cap_pin_q);

  always_comb begin
    cap_edge = 1'b0;
    case (ctrl_q.pin_action_field)
      PTPC_PIN_RISE: cap_edge = cap_now & ~cap_prev;
      PTPC_PIN_FALL: cap_edge = ~cap_now & cap_prev;
      PTPC_PIN_BOTH: cap_edge = cap_now ^ cap_prev;
      PTPC_PIN_NONE: cap_edge = 1'b0;
      default:       cap_edge = 1'b0;
    endcase
  end

  logic cap_fire;
  assign cap_fire = cap_mode & run_q & cap_edge;

  logic pin_trig;
  assign pin_trig = pulse_mode & clk_pin_s & ~clk_pin_q;

  // ****************************************************************
  // Control register and run bit
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      if (req.byteenable[0]) begin
        ctrl_q.timer_mode_field       <= req.writedata[PTPC_B_MODE+:2];
        ctrl_q.pin_action_field       <= req.writedata[PTPC_B_PIN+:2];
        ctrl_q.capture_source_select  <= req.writedata[PTPC_B_CAPSRC];
        ctrl_q.clear_source_select    <= req.writedata[PTPC_B_CLRSRC];
        ctrl_q.output_initial_level   <= req.writedata[PTPC_B_INITLVL];
      end
      if (req.byteenable[1]) begin
        ctrl_q.output_polarity_select <= req.writedata[PTPC_B_POL];
      end
    end
  end

  // Pin trigger or software set beats the A-match clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
    end else if (pin_trig) begin
      run_q <= 1'b1;
    end else if (wr_ctrl && req.byteenable[0]) begin
      run_q <= req.writedata[PTPC_B_RUN];
    end else if (match_a) begin
      run_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= run_q;
    end
  end

  // ****************************************************************
  // Counter
  // ****************************************************************
  // An A match holds the count so software can read back the width
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= PTPC_CNT_RST;
    end else if (run_rise) begin
      cnt_q <= PTPC_CNT_RST;
    end else if (match_p) begin
      cnt_q <= PTPC_CNT_RST;
    end else if (run_q && !match_a) begin
      // Wraps naturally from full scale; captures do not disturb it
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ****************************************************************
  // Compare values
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmpa_q <= '0;
    end else if (cap_fire) begin
      cmpa_q <= cnt_q;
    end else if (wr_cmpa) begin
      if (req.byteenable[0]) cmpa_q[7:0] <= req.writedata[7:0];
      if (req.byteenable[1]) cmpa_q[9:8] <= req.writedata[9:8];
    end
  end

  // P is written in any mode but only compared in capture mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmpp_q <= '0;
    end else if (wr_cmpp) begin
      if (req.byteenable[0]) cmpp_q[7:0] <= req.writedata[7:0];
      if (req.byteenable[1]) cmpp_q[9:8] <= req.writedata[9:8];
    end
  end

  // ****************************************************************
  // Output pin and interrupt
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
    end else if (pulse_mode) begin
      out_q <= run_q;
    end else begin
      out_q <= 1'b0;
    end
  end
  assign timer_out_o = out_q;

  logic irq_set;
  assign irq_set = match_a | match_p | cap_fire;

  // Sticky request; an event in the clear cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else if (irq_set) begin
      irq_q <= 1'b1;
    end else if (wr_stat && req.byteenable[0] && req.writedata[0]) begin
      irq_q <= 1'b0;
    end
  end
  assign timer_irq_o = irq_q;

  // ****************************************************************
  // Status flags
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_seen_q <= 1'b0;
    end else if (cap_fire) begin
      capture_seen_q <= 1'b1;
    end else if (run_rise) begin
      capture_seen_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= PTPC_RD_UNMAP;
    end else if (rd_go) begin
      avs_readdata_o <= PTPC_RD_UNMAP;
      if (hit(req.address, PTPC_OFS_CTRL)) begin
        avs_readdata_o[PTPC_CTRL_W-1:0] <= {ctrl_q.output_polarity_select,
          ctrl_q.output_initial_level, ctrl_q.clear_source_select,
          ctrl_q.capture_source_select, ctrl_q.pin_action_field,
          ctrl_q.timer_mode_field, run_q};
      end else if (hit(req.address, PTPC_OFS_CMPA)) begin
        avs_readdata_o[CNT_W-1:0] <= cmpa_q;
      end else if (hit(req.address, PTPC_OFS_CMPP)) begin
        avs_readdata_o[CNT_W-1:0] <= cmpp_q;
      end else if (hit(req.address, PTPC_OFS_COUNT)) begin
        avs_readdata_o[CNT_W-1:0] <= cnt_q;
      end else if (hit(req.address, PTPC_OFS_STAT)) begin
        avs_readdata_o[2:0] <= {out_q, capture_seen_q, irq_q};
      end
    end
  end

endmodule // ptpc_timer

/* File: core/ptpc_pkg.sv */
// Package for the periodic timer pulse/capture block: register map, fields, constants.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
package ptpc_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [4:0] PTPC_OFS_CTRL  = 5'h00;
  localparam logic [4:0] PTPC_OFS_CMPA  = 5'h04;
  localparam logic [4:0] PTPC_OFS_CMPP  = 5'h08;
  localparam logic [4:0] PTPC_OFS_COUNT = 5'h0C;
  localparam logic [4:0] PTPC_OFS_STAT  = 5'h10;

  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int PTPC_B_RUN     = 0;
  localparam int PTPC_B_MODE    = 1;
  localparam int PTPC_B_PIN     = 3;
  localparam int PTPC_B_CAPSRC  = 5;
  localparam int PTPC_B_CLRSRC  = 6;
  localparam int PTPC_B_INITLVL = 7;
  localparam int PTPC_B_POL     = 8;
  localparam int PTPC_CTRL_W    = 9;

  localparam logic [1:0] PTPC_MODE_CAPTURE = 2'h1;
  localparam logic [1:0] PTPC_MODE_PULSE   = 2'h2;
  localparam logic [1:0] PTPC_PIN_RISE     = 2'h0;
  localparam logic [1:0] PTPC_PIN_FALL     = 2'h1;
  localparam logic [1:0] PTPC_PIN_BOTH     = 2'h2;
  localparam logic [1:0] PTPC_PIN_NONE     = 2'h3;

  localparam int          PTPC_CNT_W     = 10;
  localparam logic [9:0]  PTPC_CNT_MAX   = 10'h3FF;
  localparam logic [9:0]  PTPC_CNT_RST   = 10'h000;
  localparam logic [31:0] PTPC_RD_UNMAP  = 32'h0000_0000;
  localparam int          PTPC_SYNC_LEN  = 3;

  typedef struct packed {
    logic       clear_source_select;
    logic       output_polarity_select;
    logic       output_initial_level;
    logic       capture_source_select;
    logic [1:0] pin_action_field;
    logic [1:0] timer_mode_field;
    logic       run_enable_bit;
  } ptpc_ctrl_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } ptpc_avm_req_t;

endpackage

/* File: core/ptpc_sync.sv */
// Three-stage synchroniser with agreement filter for one pin input.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/1ns
module ptpc_sync #(
  parameter int STAGES = ptpc_pkg::PTPC_SYNC_LEN
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o
);
  import ptpc_pkg::*;

  logic [STAGES-1:0] sh_q;

  initial begin
    if (STAGES != 3) $error("ptpc_sync needs exactly three stages");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_q <= '0;
    end else begin
      sh_q <= {sh_q[STAGES-2:0], pin_i};
    end
  end

  // Only stages two and three are compared; stage one feeds stage two alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
    end else if (sh_q[1] == sh_q[2]) begin
      level_o <= sh_q[2];
    end
  end

endmodule // ptpc_sync

/* File: dv/ptpc_chk.sv */
// Concurrent checks on the timer block ports.
// Assumes it is bound into every ptpc_timer instance.
`timescale 1ns/1ns
module ptpc_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        ext_timer_clock_pin_i,
  input wire logic        dedicated_capture_pin_i,
  input wire logic        timer_out_o,
  input wire logic        timer_irq_o
);
  // ****************************************
  // Cycles since the clock pin last moved
  // ****************************************
  logic       pin_q;
  logic [3:0] age_q;
  wire        req_w = avs_read_i | avs_write_i;
  always_ff @(posedge clk_i) begin
    pin_q <= ext_timer_clock_pin_i;
    if (rst_i || pin_q != ext_timer_clock_pin_i) begin
      age_q <= 4'h0;
    end else if (age_q != 4'hF) begin
      age_q <= age_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_wait_first: assert property ($rose(req_w) |-> avs_waitrequest_o)
    else $error("no wait state on new request");
  a_wait_one: assert property (req_w && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait state");
  a_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without a read");
  a_rst_quiet: assert property ($fell(rst_i) |-> !timer_out_o && !timer_irq_o)
    else $error("outputs active after reset");
  a_irq_sticky: assert property (timer_irq_o && !avs_write_i |=> timer_irq_o)
    else $error("irq dropped without a write");
  a_out_cause: assert property ($rose(timer_out_o) |->
    $past(avs_write_i, 2) || $past(avs_write_i, 3) || age_q < 4'hC)
    else $error("pulse started without trigger");
  a_out_fall: assert property ($fell(timer_out_o) |->
    timer_irq_o || $past(avs_write_i, 2) || $past(avs_write_i, 3))
    else $error("pulse ended without cause");
  a_match_ends: assert property ($rose(timer_irq_o) && timer_out_o |=> !timer_out_o)
    else $error("pulse kept after match");
  cover property ($rose(timer_irq_o) && timer_out_o);
  cover property ($rose(timer_irq_o) && !timer_out_o);
  cover property (avs_read_i && !avs_waitrequest_o);
endmodule // ptpc_chk

bind ptpc_timer ptpc_chk i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .ext_timer_clock_pin_i(ext_timer_clock_pin_i),
  .dedicated_capture_pin_i(dedicated_capture_pin_i),
  .timer_out_o(timer_out_o), .timer_irq_o(timer_irq_o));

/* File: dv/ptpc_pin_src.sv */
// Model of the external pulse/edge source on the two timer pins.
// Assumes the bench sets wanted levels; bit 0 clock pin, bit 1 capture pin.
`timescale 1ns/1ns
module ptpc_pin_src (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic [1:0] lvl_i,
  output logic [1:0]      pin_o
);
  // Slow path adds a cycle so edges land at varied sync phases
  logic [1:0] d1_q = 2'h0;
  logic [1:0] d2_q = 2'h0;
  always @(posedge clk_i) begin
    d1_q <= lvl_i;
    d2_q <= d1_q;
  end
  assign pin_o = slow_i ? d2_q : d1_q;
endmodule // ptpc_pin_src

/* File: dv/test_periodic_timer_pulse_capture.sv */
// Self-checking bench for the timer pulse and capture modes.
// Assumes ptpc_pkg, the design, the pin model and the checker are compiled.
`timescale 1ns/1ns
module test_periodic_timer_pulse_capture;
  import ptpc_pkg::*;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  ptpc_avm_req_t req = '0;
  logic [31:0]   rdata_w, rd, c;
  logic          wait_w, out_w, irq_w, slow = 1'b0;
  logic [1:0]    lvl = 2'h0, sel, pa;
  logic [3:0]    be = 4'hF;
  wire  [1:0]    pin_w;
  int            err_total = 0, cmp_count = 0, seed = 32'h35f7, a, p, w;
  logic [4:0]    ofs [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14};
  always #4 clk_i = ~clk_i;
  ptpc_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(req.address),
    .avs_read_i(req.read), .avs_write_i(req.write), .avs_byteenable_i(req.byteenable),
    .avs_writedata_i(req.writedata), .avs_readdata_o(rdata_w), .avs_waitrequest_o(wait_w),
    .ext_timer_clock_pin_i(pin_w[0]), .dedicated_capture_pin_i(pin_w[1]),
    .timer_out_o(out_w), .timer_irq_o(irq_w));
  ptpc_pin_src i_src (.clk_i(clk_i), .slow_i(slow), .lvl_i(lvl), .pin_o(pin_w));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic cap_exp(input logic [1:0] act, input logic rise);
    return act == PTPC_PIN_BOTH || act == (rise ? PTPC_PIN_RISE : PTPC_PIN_FALL);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{read: !wr, write: wr, address: ad, byteenable: be, writedata: wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_w !== 1'b0);
    chk("bus answer", 32'h0, 32'(n >= 64));
    rd = rdata_w;
    req <= '0;
  endtask
  task automatic rc(input logic [4:0] ad, input logic [31:0] e, input string nm);
    bus(1'b0, ad, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic wait_out(input logic lv, input int lim);
    w = 0;
    while (out_w !== lv && w < lim) begin
      @(posedge clk_i);
      w++;
    end
    chk("out level", 32'(lv), 32'(out_w));
  endtask
  task automatic conclude();
    $display("comparisons %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    // About seven times the two thousand or so cycles the scenarios need
    #120000;
    err_total++;
    conclude();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ofs[i]) rc(ofs[i], 32'h0, "reset value");
    bus(1'b1, PTPC_OFS_CMPA, 32'hFFFF_FFFF);
    rc(PTPC_OFS_CMPA, 32'h3FF, "cmpa width");
    be = 4'h1;
    bus(1'b1, PTPC_OFS_CMPA, 32'h0000_0155);
    be = 4'h2;
    bus(1'b1, PTPC_OFS_CMPA, 32'h0000_0100);
    be = 4'hF;
    rc(PTPC_OFS_CMPA, 32'h155, "cmpa lanes");
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    rc(5'h14, 32'h0, "unmapped");
    // Pulses: two by software, two by clock pin; P below A must not matter
    for (int k = 0; k < 4; k++) begin
      a = 3 + ($unsigned($random(seed)) % 40);
      slow <= k[0];
      bus(1'b1, PTPC_OFS_CMPP, 32'h2);
      bus(1'b1, PTPC_OFS_CMPA, a);
      bus(1'b1, PTPC_OFS_STAT, 32'h1);
      bus(1'b1, PTPC_OFS_CTRL, (k < 2) ? 32'h5D : 32'h5C);
      if (k >= 2) lvl <= 2'h1;
      wait_out(1'b1, 40);
      wait_out(1'b0, 200);
      chk("pulse width", a + 2, w);
      chk("pulse irq", 32'h1, 32'(irq_w));
      lvl <= 2'h0;
      rc(PTPC_OFS_CTRL, 32'h5C, "run cleared");
      rc(PTPC_OFS_COUNT, a, "count held");
    end
    // Software abort: trailing edge without match or irq
    bus(1'b1, PTPC_OFS_CMPA, 32'h300);
    bus(1'b1, PTPC_OFS_STAT, 32'h1);
    bus(1'b1, PTPC_OFS_CTRL, 32'h1D);
    wait_out(1'b1, 40);
    bus(1'b1, PTPC_OFS_CTRL, 32'h1C);
    wait_out(1'b0, 10);
    chk("abort irq", 32'h0, 32'(irq_w));
    // Capture: every pin action on both sources, unselected pin moves first
    bus(1'b1, PTPC_OFS_CMPP, 32'h0);
    for (int i = 0; i < 8; i++) begin
      pa = 2'(i);
      sel = (i < 4) ? 2'h2 : 2'h1;
      bus(1'b1, PTPC_OFS_CMPA, 32'h3FF);
      bus(1'b1, PTPC_OFS_CTRL, 32'h183 | (pa << 3) | ((i / 4) << 5));
      for (int e = 0; e < 3; e++) begin
        bus(1'b1, PTPC_OFS_STAT, 32'h1);
        lvl <= (e == 1) ? 2'h3 : ~sel;
        slow <= 1'($random(seed));
        repeat (12) @(posedge clk_i);
        bus(1'b0, PTPC_OFS_STAT, 32'h0);
        chk("capture irq", (e == 0) ? 1'b0 : cap_exp(pa, e == 1), rd[0]);
        chk("out idle", 32'h0, 32'(out_w));
      end
      bus(1'b0, PTPC_OFS_CMPA, 32'h0);
      a = rd;
      chk("cmpa loaded", 32'(pa != PTPC_PIN_NONE), 32'(a != 32'h3FF));
      bus(1'b0, PTPC_OFS_COUNT, 32'h0);
      c = rd;
      bus(1'b0, PTPC_OFS_COUNT, 32'h0);
      chk("count runs", 32'h1, 32'(rd != c));
      chk("cmpa kept", 32'h1, 32'(pa == PTPC_PIN_NONE || a < c));
      lvl <= 2'h0;
    end
    // Wrap at P, then P zero runs to the top
    p = 8 + ($unsigned($random(seed)) % 32);
    bus(1'b1, PTPC_OFS_CTRL, 32'h0);
    bus(1'b1, PTPC_OFS_CMPP, p);
    bus(1'b1, PTPC_OFS_STAT, 32'h1);
    bus(1'b1, PTPC_OFS_CTRL, 32'h1B);
    repeat (50) @(posedge clk_i);
    for (int j = 0; j < 4; j++) begin
      bus(1'b0, PTPC_OFS_COUNT, 32'h0);
      chk("count bound", 32'h1, 32'(rd <= p));
    end
    chk("wrap irq", 32'h1, 32'(irq_w));
    bus(1'b1, PTPC_OFS_CTRL, 32'h0);
    bus(1'b1, PTPC_OFS_CMPP, 32'h0);
    bus(1'b1, PTPC_OFS_STAT, 32'h1);
    bus(1'b1, PTPC_OFS_CTRL, 32'h1B);
    repeat (600) @(posedge clk_i);
    bus(1'b0, PTPC_OFS_COUNT, 32'h0);
    chk("count past p", 32'h1, 32'(rd > 32'h200));
    chk("no early wrap", 32'h0, 32'(irq_w));
    repeat (500) @(posedge clk_i);
    chk("top wrap irq", 32'h1, 32'(irq_w));
    conclude();
  end
endmodule // test_periodic_timer_pulse_capture
